//--- rtl/qpd_defines.vh
// constants for the quad pot command decoder: opcodes, field positions, timing
// assumes inclusion by bare name from the design file
`ifndef QPD_DEFINES_VH
`define QPD_DEFINES_VH

// system clock and nonvolatile write time
`define QPD_CLK_MHZ 100
`define QPD_NV_WRITE_US 10000
`define QPD_NV_WRITE_CYCLES 20'd1000000

// instruction byte fields
`define QPD_OPC_HI 7
`define QPD_OPC_LO 4
`define QPD_SLOT_HI 3
`define QPD_SLOT_LO 2
`define QPD_POT_HI 1
`define QPD_POT_LO 0

// address byte fields
`define QPD_TYPE_HI 7
`define QPD_TYPE_LO 4
`define QPD_CHIP_HI 3
`define QPD_CHIP_LO 0

// instruction opcodes
`define QPD_OPC_READ_WIPER 4'h9
`define QPD_OPC_WRITE_WIPER 4'ha
`define QPD_OPC_READ_STORED 4'hb
`define QPD_OPC_WRITE_STORED 4'hc
`define QPD_OPC_COPY_TO_WIPER 4'hd
`define QPD_OPC_SAVE_WIPER 4'he
`define QPD_OPC_GLOBAL_TO_WIPER 4'h1
`define QPD_OPC_GLOBAL_SAVE 4'h8
`define QPD_OPC_STEP 4'h2

// register geometry
`define QPD_VAL_W 6
`define QPD_POTS 4
`define QPD_SLOTS 4
`define QPD_WIPER_MAX 6'h3f
`define QPD_WIPER_MIN 6'h00
`define QPD_WIPER_RESET 24'h000000
`define QPD_POWER_UP_SLOT 2'h0

`endif

//--- rtl/qpd_decoder.v
// command decoder and register store of a quad digital potentiometer
// assumes scl, sda and chip strap pins are asynchronous to sys_clk and
// that sda is open drain with an external pull-up resolved in the bench
`include "qpd_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module qpd_decoder
#(
    parameter [3:0] DEVICE_TYPE = 4'ha, // arbitrary value, not a real part code
    parameter integer NV_CNT_W = 20,
    parameter [NV_CNT_W-1:0] NV_WRITE_CYCLES = `QPD_NV_WRITE_CYCLES
)
(
    input wire sys_clk, // system clock, 100 MHz
    input wire reset, // asynchronous reset, active high
    input wire scl, // serial clock pin from host
    input wire sda_in, // serial data pin level
    output reg sda_out, // serial data drive level, always low
    output reg sda_oe, // high while pulling sda low
    input wire [3:0] chip_select_bits, // strapped chip address pins
    output reg [23:0] wiper_taps, // four wiper positions, pot 0 in low bits
    output reg nv_busy // nonvolatile write in progress
);

    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_ADDR = 7'h02;
    localparam [6:0] ST_INSTR = 7'h04;
    localparam [6:0] ST_WDATA = 7'h08;
    localparam [6:0] ST_RDATA = 7'h10;
    localparam [6:0] ST_STEP = 7'h20;
    localparam [6:0] ST_WAIT = 7'h40;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and bus condition detection

    reg scl_meta;
    reg scl_s;
    reg scl_d;
    reg sda_meta;
    reg sda_s;
    reg sda_d;
    reg [3:0] chip_meta;
    reg [3:0] chip_s;

    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            scl_meta <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_meta <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
            chip_meta <= 4'h0;
            chip_s <= 4'h0;
        end
        else
        begin
            scl_meta <= scl;
            scl_s <= scl_meta;
            scl_d <= scl_s;
            sda_meta <= sda_in;
            sda_s <= sda_meta;
            sda_d <= sda_s;
            chip_meta <= chip_select_bits;
            chip_s <= chip_meta;
        end
    end

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
    wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;

    ////////////////////////////////////////////////////////////////////////////
    // stored-setting array, nonvolatile so it carries no reset

    reg [5:0] stored_setting [0:15];
    reg [6:0] state;
    reg [3:0] bit_cnt;
    reg ack_phase;
    reg [7:0] shift;
    reg [7:0] rd_shift;
    reg power_up_pending;
    reg pend_valid;
    reg [3:0] pend_mask;
    reg [1:0] pend_slot;
    reg [23:0] pend_data;
    reg [NV_CNT_W-1:0] nv_cnt;

    wire [3:0] opcode = shift[`QPD_OPC_HI:`QPD_OPC_LO];
    wire [1:0] slot_select = shift[`QPD_SLOT_HI:`QPD_SLOT_LO];
    wire [1:0] pot_select = shift[`QPD_POT_HI:`QPD_POT_LO];
    wire [3:0] slot_index = {pot_select, slot_select};
    wire addr_match = (shift[`QPD_TYPE_HI:`QPD_TYPE_LO] == DEVICE_TYPE)
        && (shift[`QPD_CHIP_HI:`QPD_CHIP_LO] == chip_s);
    wire nv_done = nv_busy && (nv_cnt == NV_WRITE_CYCLES - 1'b1);

    integer p;
    integer c;

    // commit of a timed write at the end of the write cycle
    always @(posedge sys_clk)
    begin
        if (nv_done)
        begin
            for (c = 0; c < `QPD_POTS; c = c + 1)
            begin
                if (pend_mask[c])
                begin
                    stored_setting[c * `QPD_SLOTS + pend_slot] <= pend_data[c * 6 +: 6];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // nonvolatile write timer

    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            nv_busy <= 1'b0;
            nv_cnt <= {NV_CNT_W{1'b0}};
        end
        else if (nv_busy)
        begin
            nv_cnt <= nv_cnt + 1'b1;
            if (nv_done)
            begin
                nv_busy <= 1'b0;
            end
        end
        else if (bus_stop && pend_valid)
        begin
            nv_busy <= 1'b1;
            nv_cnt <= {NV_CNT_W{1'b0}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial command engine

    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
            shift <= 8'h00;
            rd_shift <= 8'h00;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            wiper_taps <= `QPD_WIPER_RESET;
            power_up_pending <= 1'b1;
            pend_valid <= 1'b0;
            pend_mask <= 4'h0;
            pend_slot <= 2'h0;
            pend_data <= 24'h000000;
        end
        else if (power_up_pending)
        begin
            power_up_pending <= 1'b0;
            for (p = 0; p < `QPD_POTS; p = p + 1)
            begin
                wiper_taps[p * 6 +: 6] <= stored_setting[p * `QPD_SLOTS + `QPD_POWER_UP_SLOT];
            end
        end
        else if (bus_start)
        begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
            sda_oe <= 1'b0;
            pend_valid <= 1'b0;
        end
        else if (bus_stop)
        begin
            // a stop ends every sequence, step mode included
            state <= ST_IDLE;
            sda_oe <= 1'b0;
            pend_valid <= 1'b0;
        end
        else
        begin
            case (state)
                ST_ADDR, ST_INSTR, ST_WDATA:
                begin
                    if (scl_rise && !ack_phase && bit_cnt != 4'h8)
                    begin
                        shift <= {shift[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    else if (scl_fall && !ack_phase && bit_cnt == 4'h8)
                    begin
                        if (state == ST_ADDR && (!addr_match || nv_busy))
                        begin
                            state <= ST_WAIT;
                        end
                        else
                        begin
                            ack_phase <= 1'b1;
                            sda_oe <= 1'b1;
                        end
                    end
                    else if (scl_fall && ack_phase)
                    begin
                        ack_phase <= 1'b0;
                        sda_oe <= 1'b0;
                        bit_cnt <= 4'h0;
                        if (state == ST_ADDR)
                        begin
                            state <= ST_INSTR;
                        end
                        else if (state == ST_WDATA)
                        begin
                            state <= ST_WAIT;
                            if (rd_shift[0])
                            begin
                                wiper_taps[pend_slot * 6 +: 6] <= shift[5:0];
                            end
                            else
                            begin
                                pend_valid <= 1'b1;
                                // every lane holds the byte, the mask picks the pot
                                pend_data <= {4{shift[5:0]}};
                            end
                        end
                        else
                        begin
                            // slot bits of wiper-only opcodes and pot bits of
                            // global opcodes play no part in the decode
                            state <= ST_WAIT;
                            pend_slot <= slot_select;
                            case (opcode)
                                `QPD_OPC_READ_WIPER:
                                begin
                                    state <= ST_RDATA;
                                    rd_shift <= {2'b00, wiper_taps[pot_select * 6 +: 6]};
                                    sda_oe <= 1'b1;
                                end
                                `QPD_OPC_READ_STORED:
                                begin
                                    state <= ST_RDATA;
                                    rd_shift <= {2'b00, stored_setting[slot_index]};
                                    sda_oe <= 1'b1;
                                end
                                `QPD_OPC_WRITE_WIPER:
                                begin
                                    state <= ST_WDATA;
                                    rd_shift <= 8'h01;
                                    pend_slot <= pot_select;
                                end
                                `QPD_OPC_WRITE_STORED:
                                begin
                                    state <= ST_WDATA;
                                    rd_shift <= 8'h00;
                                    pend_mask <= 4'h1 << pot_select;
                                end
                                `QPD_OPC_COPY_TO_WIPER:
                                begin
                                    wiper_taps[pot_select * 6 +: 6] <= stored_setting[slot_index];
                                end
                                `QPD_OPC_SAVE_WIPER:
                                begin
                                    pend_valid <= 1'b1;
                                    pend_mask <= 4'h1 << pot_select;
                                    pend_data <= wiper_taps;
                                end
                                `QPD_OPC_GLOBAL_TO_WIPER:
                                begin
                                    for (p = 0; p < `QPD_POTS; p = p + 1)
                                    begin
                                        wiper_taps[p * 6 +: 6] <= stored_setting[p * `QPD_SLOTS + slot_select];
                                    end
                                end
                                `QPD_OPC_GLOBAL_SAVE:
                                begin
                                    pend_valid <= 1'b1;
                                    pend_mask <= 4'hf;
                                    pend_data <= wiper_taps;
                                end
                                `QPD_OPC_STEP:
                                begin
                                    state <= ST_STEP;
                                    pend_slot <= pot_select;
                                end
                                default:
                                begin
                                    state <= ST_WAIT;
                                end
                            endcase
                        end
                    end
                end
                ST_RDATA:
                begin
                    if (scl_rise)
                    begin
                        rd_shift <= {rd_shift[6:0], 1'b1};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    else if (scl_fall && bit_cnt != 4'h8)
                    begin
                        sda_oe <= ~rd_shift[7];
                    end
                    else if (scl_fall)
                    begin
                        // release for the host acknowledge, then wait for stop
                        sda_oe <= 1'b0;
                        state <= ST_WAIT;
                    end
                end
                ST_STEP:
                begin
                    if (scl_rise && sda_s && wiper_taps[pend_slot * 6 +: 6] != `QPD_WIPER_MAX)
                    begin
                        wiper_taps[pend_slot * 6 +: 6] <= wiper_taps[pend_slot * 6 +: 6] + 6'h01;
                    end
                    else if (scl_rise && !sda_s
                        && wiper_taps[pend_slot * 6 +: 6] != `QPD_WIPER_MIN)
                    begin
                        wiper_taps[pend_slot * 6 +: 6] <= wiper_taps[pend_slot * 6 +: 6] - 6'h01;
                    end
                end
                ST_IDLE, ST_WAIT:
                begin
                    sda_oe <= 1'b0;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // qpd_decoder

`default_nettype wire

//--- dv/qpd_host_model.sv
// host bus master model for the serial link of the pot decoder
// assumes the bench resolves sda as a wired-and with a pull-up
`timescale 1ns/10ps
`default_nettype none
module qpd_host_model (
    output logic scl, // serial clock, idle high, still outside frames
    output logic sda_drv, // 0 pulls sda low, 1 releases
    input wire logic sda // resolved sda level
);
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    ////////////////////////////////////////
    task automatic bit_out(input logic b);
        sda_drv = b;
        #31.25 scl = 1'b1;
        #62.5 scl = 1'b0; // sda steady over the high phase
        #31.25;
    endtask
    task automatic bit_in(output logic b);
        sda_drv = 1'b1;
        #31.25 scl = 1'b1;
        #31.25 b = sda;
        #31.25 scl = 1'b0;
        #31.25;
    endtask
    task automatic start();
        #62.5 sda_drv = 1'b0;
        #62.5 scl = 1'b0;
        #31.25;
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        #31.25 scl = 1'b1;
        #62.5 sda_drv = 1'b1;
        #125;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_out(d[i]);
        bit_in(a);
        ack = ~a;
    endtask
    task automatic rd_byte(output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            bit_in(d[i]);
        bit_out(1'b0); // host acknowledges read data before stop
    endtask
endmodule // qpd_host_model
`default_nettype wire

//--- dv/qpd_decoder_asserts.sv
// port-level checks of the pot decoder
// assumes binding onto qpd_decoder with its count parameters
`timescale 1ns/10ps
`default_nettype none
module qpd_decoder_asserts #(
    parameter integer NV_CNT_W = 20,
    parameter [NV_CNT_W-1:0] NV_WRITE_CYCLES = 20'd20
) (
    input wire logic sys_clk, // system clock
    input wire logic reset, // async reset, active high
    input wire logic scl, // serial clock pin
    input wire logic sda_in, // sda level
    input wire logic sda_out, // sda drive value
    input wire logic sda_oe, // sda pull enable
    input wire logic [3:0] chip_select_bits, // chip strap
    input wire logic [23:0] wiper_taps, // wiper positions
    input wire logic nv_busy // nonvolatile write running
);
    logic [NV_CNT_W-1:0] busy_cnt;
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            busy_cnt <= '0;
        else if (nv_busy)
            busy_cnt <= busy_cnt + 1'b1;
        else
            busy_cnt <= '0;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    a_sda_out_low: assert property (sda_out == 1'b0)
        else $error("sda drive value not low");
    a_busy_len: assert property ($fell(nv_busy) |-> busy_cnt == NV_WRITE_CYCLES)
        else $error("write timer length wrong");
    a_busy_bound: assert property (nv_busy |-> busy_cnt < NV_WRITE_CYCLES)
        else $error("write timer overran");
    a_busy_after_stop: assert property ($rose(nv_busy) |-> scl && sda_in)
        else $error("write started outside stop");
    a_wiper_busy: assert property (nv_busy |-> $stable(wiper_taps))
        else $error("wiper moved during write");
    a_oe_scl_low: assert property (!$stable(sda_oe) |-> !scl)
        else $error("sda drive changed while scl high");
    a_nak_busy: assert property (nv_busy |-> !sda_oe)
        else $error("device drove sda while busy");
    a_reset_quiet: assert property (disable iff (1'b0)
        reset |-> !sda_oe && !nv_busy && wiper_taps == 24'h000000)
        else $error("outputs not cleared in reset");
endmodule // qpd_decoder_asserts
`default_nettype wire

//--- dv/qpd_decoder_tb.sv
// self-checking bench of the pot decoder driven through the serial link
// assumes qpd_host_model as bus master and a pull-up on sda
`timescale 1ns/10ps
`default_nettype none
module qpd_decoder_tb;
    localparam [3:0] DEV = 4'h6; // arbitrary type code
    localparam [3:0] CHIP = 4'h9;
    localparam [19:0] NVC = 20'd200;
    logic sys_clk = 1'b0;
    logic reset = 1'b0;
    logic [3:0] chip_bits = CHIP;
    wire scl;
    wire host_sda;
    wire sda_oe;
    wire sda_out;
    wire sda_w = host_sda & ~sda_oe;
    wire [23:0] wiper_taps;
    wire nv_busy;
    logic [5:0] mem [16];
    logic [5:0] wip [4];
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    qpd_decoder #(.DEVICE_TYPE(DEV), .NV_CNT_W(20), .NV_WRITE_CYCLES(NVC)) u_qpd_decoder (
        .sys_clk(sys_clk), .reset(reset), .scl(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe), .chip_select_bits(chip_bits), .wiper_taps(wiper_taps),
        .nv_busy(nv_busy));
    qpd_host_model u_qpd_host_model (.scl(scl), .sda_drv(host_sda), .sda(sda_w));
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cmd(input logic [7:0] ins, input int mode, input logic [7:0] d,
        output logic [7:0] q);
        logic a;
        q = 8'h00;
        u_qpd_host_model.start();
        u_qpd_host_model.wr_byte({DEV, CHIP}, a);
        check("addr ack", a, 1'b1);
        u_qpd_host_model.wr_byte(ins, a);
        check("instr ack", a, 1'b1);
        if (mode == 1)
        begin
            u_qpd_host_model.wr_byte(d, a);
            check("data ack", a, 1'b1);
        end
        if (mode == 2)
            u_qpd_host_model.rd_byte(q);
        if (mode != 3)
            u_qpd_host_model.stop();
    endtask
    task automatic nv_wait();
        int n;
        n = 0;
        check("busy", nv_busy, 1'b1);
        while (nv_busy !== 1'b0 && n < 400)
        begin
            @(posedge sys_clk);
            n++;
        end
        check("busy done", n < 400, 1'b1);
    endtask
    function automatic logic [23:0] taps();
        return {wip[3], wip[2], wip[1], wip[0]};
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            err_count++;
            wrap_up();
        end
    end
    ////////////////////////////////////////
    initial
    begin
        logic [7:0] q;
        logic a;
        logic [5:0] w;
        #1 reset = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1 reset = 1'b0;
        repeat (8) @(posedge sys_clk);
        // blank slots recall unknown wipers, so give every wiper a value first
        for (int p = 0; p < 4; p++)
        begin
            wip[p] = {p[1:0], 4'ha};
            cmd({6'h28, p[1:0]}, 1, {2'b00, wip[p]}, q);
        end
        check("first wipers", wiper_taps, taps());
        for (int k = 0; k < 16; k++)
        begin
            mem[k] = {k[3:0], ~k[3:2]};
            cmd({4'hc, k[3:0]}, 1, {2'b00, mem[k]}, q);
            if (k == 0)
            begin
                u_qpd_host_model.start();
                u_qpd_host_model.wr_byte({DEV, CHIP}, a);
                check("busy nak", a, 1'b0);
                u_qpd_host_model.stop();
            end
            else
                nv_wait();
        end
        #1 reset = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1 reset = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        for (int p = 0; p < 4; p++)
            wip[p] = mem[p];
        check("recall", wiper_taps, taps());
        repeat (8) @(posedge sys_clk);
        for (int k = 0; k < 16; k++)
        begin
            cmd({4'hb, k[3:0]}, 2, 8'h00, q);
            check("read stored", q, {2'b00, mem[k]});
        end
        cmd(8'ha2, 1, 8'h15, q);
        wip[2] = 6'h15;
        check("write wiper", wiper_taps, taps());
        for (int p = 0; p < 4; p++)
        begin
            cmd({6'h24, p[1:0]}, 2, 8'h00, q);
            check("read wiper", q, {2'b00, wip[p]});
        end
        cmd(8'hd6, 0, 8'h00, q);
        wip[2] = mem[6];
        check("copy", wiper_taps, taps());
        cmd(8'h1c, 0, 8'h00, q);
        for (int p = 0; p < 4; p++)
            wip[p] = mem[12 + p];
        check("global copy", wiper_taps, taps());
        cmd(8'he1, 0, 8'h00, q);
        mem[1] = wip[1];
        nv_wait();
        cmd(8'h88, 0, 8'h00, q);
        for (int p = 0; p < 4; p++)
            mem[8 + p] = wip[p];
        nv_wait();
        for (int k = 0; k < 12; k++)
        begin
            cmd({4'hb, k[3:0]}, 2, 8'h00, q);
            check("saved", q, {2'b00, mem[k]});
        end
        for (int k = 0; k < 2; k++)
        begin
            u_qpd_host_model.start();
            u_qpd_host_model.wr_byte(k == 0 ? {DEV, ~CHIP} : {~DEV, CHIP}, a);
            check("addr nak", a, 1'b0);
            u_qpd_host_model.stop();
        end
        check("no change", wiper_taps, taps());
        cmd(8'ha3, 1, 8'h3e, q);
        w = 6'h3e;
        cmd(8'h23, 3, 8'h00, q);
        for (int i = 0; i < 5; i++)
        begin
            u_qpd_host_model.bit_out(i < 2);
            if (i < 2)
                w = (w == 6'h3f) ? w : w + 6'h01;
            else
                w = (w == 6'h00) ? w : w - 6'h01;
            wip[3] = w;
            check("step", wiper_taps, taps());
        end
        u_qpd_host_model.stop();
        wrap_up();
    end
endmodule // qpd_decoder_tb
bind qpd_decoder qpd_decoder_asserts #(.NV_CNT_W(NV_CNT_W), .NV_WRITE_CYCLES(NV_WRITE_CYCLES))
    u_qpd_decoder_asserts (.sys_clk(sys_clk), .reset(reset), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_bits(chip_select_bits),
    .wiper_taps(wiper_taps), .nv_busy(nv_busy));
`default_nettype wire
